// ==== hdl/cell_protection_pkg.sv ====
// Constants, types and delay figures for the cell protection sequencer
//
// Overview of operation
// - Overcharge held for delay drops charge gate
// - Short overcharge excursion ignored, count restarts
// - Overcharge released at release level or unplug plus load
// - Overcharge release condition must hold 16 ms
// - Unplugged above detect level keeps charge off
// - Overdischarge held for delay drops discharge gate
// - Short overdischarge excursion is ignored
// - Charger present: release above detect level
// - No charger: release at release level
// - Overdischarge asserts standby request
// - Depleted cell with charger enables charging
// - Excess discharge current held drops discharge gate
// - Short excess discharge excursion is ignored
// - Short level held 300 us drops discharge
// - Pull-down only in excess current or short
// - Sense low for release delay clears both
// - Excess discharge current beats overdischarge
// - Excess charge current held drops charge gate
// - Short excess charge excursion is ignored
// - Excess charge released by unplug plus load
// - Shortening level cuts three delays while charging
// - Excess charge release waits 1.2 ms
package cell_protection_pkg;

  // ****************************************
  // Clock and delay figures
  // ****************************************
  localparam real CLK_HZ = 100000000.0;
  localparam real OC_DETECT_DELAY_S = 1.0;
  localparam real OC_RELEASE_DELAY_MS = 16.0;
  localparam real OD_DETECT_DELAY_MS = 20.0;
  localparam real OD_RELEASE_DELAY_MS = 1.2;
  localparam real EDC_DETECT_DELAY_MS = 12.0;
  localparam real EDC_RELEASE_DELAY_MS = 1.2;
  localparam real SHORT_DETECT_DELAY_US = 300.0;
  localparam real ECC_DETECT_DELAY_MS = 8.0;
  localparam real ECC_RELEASE_DELAY_MS = 1.2;

  localparam int unsigned OC_DETECT_CYCLES_DEF = int'(OC_DETECT_DELAY_S * CLK_HZ);
  localparam int unsigned OC_RELEASE_CYCLES_DEF = int'(OC_RELEASE_DELAY_MS * CLK_HZ / 1000.0);
  localparam int unsigned OD_DETECT_CYCLES_DEF = int'(OD_DETECT_DELAY_MS * CLK_HZ / 1000.0);
  localparam int unsigned OD_RELEASE_CYCLES_DEF = int'(OD_RELEASE_DELAY_MS * CLK_HZ / 1000.0);
  localparam int unsigned EDC_DETECT_CYCLES_DEF = int'(EDC_DETECT_DELAY_MS * CLK_HZ / 1000.0);
  localparam int unsigned EDC_RELEASE_CYCLES_DEF = int'(EDC_RELEASE_DELAY_MS * CLK_HZ / 1000.0);
  localparam int unsigned SHORT_DETECT_CYCLES_DEF = int'(SHORT_DETECT_DELAY_US * CLK_HZ / 1.0e6);
  localparam int unsigned ECC_DETECT_CYCLES_DEF = int'(ECC_DETECT_DELAY_MS * CLK_HZ / 1000.0);
  localparam int unsigned ECC_RELEASE_CYCLES_DEF = int'(ECC_RELEASE_DELAY_MS * CLK_HZ / 1000.0);

  // Divisor applied to shortened delays
  localparam int unsigned DS_DIVISOR = 60;

  // ****************************************
  // Delay channels
  // ****************************************
  localparam int CNT_W = 27;
  localparam int NUM_DELAYS = 9;
  localparam int CH_OC_DET = 0;
  localparam int CH_OC_REL = 1;
  localparam int CH_OD_DET = 2;
  localparam int CH_OD_REL = 3;
  localparam int CH_EDC_DET = 4;
  localparam int CH_SHORT_DET = 5;
  localparam int CH_EDC_REL = 6;
  localparam int CH_ECC_DET = 7;
  localparam int CH_ECC_REL = 8;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {CHG_NORMAL, CHG_OVERCHARGE, CHG_EXCESS_CURRENT} charge_state_e;
  typedef enum logic [1:0] {DIS_NORMAL, DIS_OVERDISCHARGE, DIS_EXCESS_CURRENT, DIS_SHORT}
    discharge_state_e;

  // Comparator results, all active high
  typedef struct packed {
    logic overcharge_detector;
    logic overcharge_release_level;
    logic overdischarge_detector;
    logic overdischarge_release_level;
    logic discharge_overcurrent_detector;
    logic short_detector;
    logic charge_overcurrent_detector;
    logic delay_shortening;
    logic charger_present;
    logic load_present;
    logic cell_depleted;
  } cell_sense_s;

  typedef struct packed {
    logic charge_gate_enable;
    logic discharge_gate_enable;
    logic standby_request;
    logic sense_pulldown_enable;
  } gate_drive_s;

endpackage

// ==== hdl/cell_protection_sequencer.sv ====
// Protection state sequencer for one rechargeable cell
`timescale 1ns/1ns
module cell_protection_sequencer
  import cell_protection_pkg::*;
#(
  parameter int unsigned OC_DETECT_CYCLES = OC_DETECT_CYCLES_DEF,
  parameter int unsigned OC_RELEASE_CYCLES = OC_RELEASE_CYCLES_DEF,
  parameter int unsigned OD_DETECT_CYCLES = OD_DETECT_CYCLES_DEF,
  parameter int unsigned OD_RELEASE_CYCLES = OD_RELEASE_CYCLES_DEF,
  parameter int unsigned EDC_DETECT_CYCLES = EDC_DETECT_CYCLES_DEF,
  parameter int unsigned EDC_RELEASE_CYCLES = EDC_RELEASE_CYCLES_DEF,
  parameter int unsigned SHORT_DETECT_CYCLES = SHORT_DETECT_CYCLES_DEF,
  parameter int unsigned ECC_DETECT_CYCLES = ECC_DETECT_CYCLES_DEF,
  parameter int unsigned ECC_RELEASE_CYCLES = ECC_RELEASE_CYCLES_DEF
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire cell_sense_s sense,
  output gate_drive_s drive
);

  // ****************************************
  // Terminal counts
  // ****************************************
  function automatic logic [CNT_W-1:0] shortened(input int unsigned cycles);
    int unsigned q;
    q = cycles / DS_DIVISOR;
    if (q == 0) begin
      q = 1;
    end
    return CNT_W'(q);
  endfunction

  logic [CNT_W-1:0] term_normal [NUM_DELAYS];
  logic [CNT_W-1:0] term_short [NUM_DELAYS];

  assign term_normal[CH_OC_DET] = CNT_W'(OC_DETECT_CYCLES);
  assign term_normal[CH_OC_REL] = CNT_W'(OC_RELEASE_CYCLES);
  assign term_normal[CH_OD_DET] = CNT_W'(OD_DETECT_CYCLES);
  assign term_normal[CH_OD_REL] = CNT_W'(OD_RELEASE_CYCLES);
  assign term_normal[CH_EDC_DET] = CNT_W'(EDC_DETECT_CYCLES);
  assign term_normal[CH_SHORT_DET] = CNT_W'(SHORT_DETECT_CYCLES);
  assign term_normal[CH_EDC_REL] = CNT_W'(EDC_RELEASE_CYCLES);
  assign term_normal[CH_ECC_DET] = CNT_W'(ECC_DETECT_CYCLES);
  assign term_normal[CH_ECC_REL] = CNT_W'(ECC_RELEASE_CYCLES);

  // Only overcharge detect and both overdischarge delays shrink
  assign term_short[CH_OC_DET] = shortened(OC_DETECT_CYCLES);
  assign term_short[CH_OC_REL] = term_normal[CH_OC_REL];
  assign term_short[CH_OD_DET] = shortened(OD_DETECT_CYCLES);
  assign term_short[CH_OD_REL] = shortened(OD_RELEASE_CYCLES);
  assign term_short[CH_EDC_DET] = term_normal[CH_EDC_DET];
  assign term_short[CH_SHORT_DET] = term_normal[CH_SHORT_DET];
  assign term_short[CH_EDC_REL] = term_normal[CH_EDC_REL];
  assign term_short[CH_ECC_DET] = term_normal[CH_ECC_DET];
  assign term_short[CH_ECC_REL] = term_normal[CH_ECC_REL];

  // ****************************************
  // States and qualifying conditions
  // ****************************************
  charge_state_e chg_state;
  charge_state_e next_chg_state;
  discharge_state_e dis_state;
  discharge_state_e next_dis_state;
  logic [NUM_DELAYS-1:0] qual;
  logic [NUM_DELAYS-1:0] done;
  logic ds_active;
  logic unplugged_with_load;

  assign ds_active = drive.charge_gate_enable && sense.delay_shortening;
  assign unplugged_with_load = !sense.charger_present && sense.load_present;

  assign qual[CH_OC_DET] = (chg_state == CHG_NORMAL) && sense.overcharge_detector;
  assign qual[CH_OC_REL] = (chg_state == CHG_OVERCHARGE) && (sense.overcharge_release_level ||
    (!sense.overcharge_detector && unplugged_with_load));
  assign qual[CH_OD_DET] = (dis_state == DIS_NORMAL) && sense.overdischarge_detector &&
    !sense.discharge_overcurrent_detector;
  assign qual[CH_OD_REL] = (dis_state == DIS_OVERDISCHARGE) && (sense.charger_present ?
    !sense.overdischarge_detector : sense.overdischarge_release_level);
  assign qual[CH_EDC_DET] = (dis_state == DIS_NORMAL) && sense.discharge_overcurrent_detector &&
    !sense.short_detector;
  assign qual[CH_SHORT_DET] = ((dis_state == DIS_NORMAL) || (dis_state == DIS_EXCESS_CURRENT)) &&
    sense.short_detector;
  assign qual[CH_EDC_REL] = ((dis_state == DIS_EXCESS_CURRENT) || (dis_state == DIS_SHORT)) &&
    !sense.discharge_overcurrent_detector;
  assign qual[CH_ECC_DET] = (chg_state == CHG_NORMAL) && sense.charge_overcurrent_detector &&
    !sense.overcharge_detector;
  assign qual[CH_ECC_REL] = (chg_state == CHG_EXCESS_CURRENT) && unplugged_with_load;

  // ****************************************
  // Delay counters
  // ****************************************
  genvar gi;
  generate
    for (gi = 0; gi < NUM_DELAYS; gi++) begin : g_delay
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] term;
      assign term = ds_active ? term_short[gi] : term_normal[gi];
      assign done[gi] = qual[gi] && (cnt >= term - CNT_W'(1));
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          cnt <= '0;
        end else if (!qual[gi] || done[gi]) begin
          cnt <= '0;
        end else begin
          cnt <= cnt + CNT_W'(1);
        end
      end
    end
  endgenerate

  // ****************************************
  // Charge side next state
  // ****************************************
  always_comb begin
    next_chg_state = chg_state;
    unique case (chg_state)
      CHG_NORMAL: begin
        if (done[CH_OC_DET]) begin
          next_chg_state = CHG_OVERCHARGE;
        end else if (done[CH_ECC_DET]) begin
          next_chg_state = CHG_EXCESS_CURRENT;
        end
      end
      CHG_OVERCHARGE: begin
        if (done[CH_OC_REL]) begin
          next_chg_state = CHG_NORMAL;
        end
      end
      CHG_EXCESS_CURRENT: begin
        if (done[CH_ECC_REL]) begin
          next_chg_state = CHG_NORMAL;
        end
      end
      default: begin
        next_chg_state = CHG_NORMAL;
      end
    endcase
  end

  // ****************************************
  // Discharge side next state
  // ****************************************
  always_comb begin
    next_dis_state = dis_state;
    unique case (dis_state)
      DIS_NORMAL: begin
        if (done[CH_SHORT_DET]) begin
          next_dis_state = DIS_SHORT;
        end else if (done[CH_EDC_DET]) begin
          next_dis_state = DIS_EXCESS_CURRENT;
        end else if (done[CH_OD_DET]) begin
          next_dis_state = DIS_OVERDISCHARGE;
        end
      end
      DIS_OVERDISCHARGE: begin
        if (done[CH_OD_REL]) begin
          next_dis_state = DIS_NORMAL;
        end
      end
      DIS_EXCESS_CURRENT: begin
        if (done[CH_SHORT_DET]) begin
          next_dis_state = DIS_SHORT;
        end else if (done[CH_EDC_REL]) begin
          next_dis_state = DIS_NORMAL;
        end
      end
      DIS_SHORT: begin
        if (done[CH_EDC_REL]) begin
          next_dis_state = DIS_NORMAL;
        end
      end
    endcase
  end

  // ****************************************
  // State registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      chg_state <= CHG_NORMAL;
    end else begin
      chg_state <= next_chg_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dis_state <= DIS_NORMAL;
    end else begin
      dis_state <= next_dis_state;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive.charge_gate_enable <= 1'b1;
    end else begin
      drive.charge_gate_enable <= (next_chg_state == CHG_NORMAL) ||
        (sense.cell_depleted && sense.charger_present);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive.discharge_gate_enable <= 1'b1;
    end else begin
      drive.discharge_gate_enable <= (next_dis_state == DIS_NORMAL);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive.standby_request <= 1'b0;
    end else begin
      drive.standby_request <= (next_dis_state == DIS_OVERDISCHARGE);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      drive.sense_pulldown_enable <= 1'b0;
    end else begin
      drive.sense_pulldown_enable <= (next_dis_state == DIS_EXCESS_CURRENT) ||
        (next_dis_state == DIS_SHORT);
    end
  end

endmodule

// ==== verif/cell_protection_props.sv ====
// Assertion checker for the cell protection sequencer
`timescale 1ns/1ns
module cell_protection_props
  import cell_protection_pkg::*;
#(
  parameter int unsigned OC_DETECT_CYCLES = 1,
  parameter int unsigned OC_RELEASE_CYCLES = 1,
  parameter int unsigned OD_DETECT_CYCLES = 1,
  parameter int unsigned OD_RELEASE_CYCLES = 1,
  parameter int unsigned EDC_DETECT_CYCLES = 1,
  parameter int unsigned EDC_RELEASE_CYCLES = 1,
  parameter int unsigned SHORT_DETECT_CYCLES = 1,
  parameter int unsigned ECC_DETECT_CYCLES = 1,
  parameter int unsigned ECC_RELEASE_CYCLES = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire cell_sense_s sense,
  input wire gate_drive_s drive
);
  // ****************************************
  // Run length of each qualifying condition
  // ****************************************
  logic [8:0] cond;
  int run [9];
  assign cond = {!sense.charger_present && sense.load_present,
    sense.overcharge_release_level || (!sense.overcharge_detector && !sense.charger_present
    && sense.load_present),
    !sense.discharge_overcurrent_detector,
    sense.charger_present ? !sense.overdischarge_detector : sense.overdischarge_release_level,
    sense.short_detector, sense.discharge_overcurrent_detector,
    sense.overdischarge_detector, sense.charge_overcurrent_detector,
    sense.overcharge_detector};
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 9; i++) begin
      run[i] <= (!rst_n || !cond[i]) ? 0 : run[i] + 1;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking dcb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_charge_drop;
    $fell(drive.charge_gate_enable);
  endsequence
  sequence s_pulldown_drop;
    $fell(drive.sense_pulldown_enable);
  endsequence

  a_reset_gates_high: assert property ($rose(rst_n) |-> drive == 4'hC)
    else $error("gates not high after reset");
  a_pulldown_cause: assert property ($rose(drive.sense_pulldown_enable)
    |-> $past(sense.discharge_overcurrent_detector)) else $error("pulldown without cause");
  a_standby_exclusive: assert property (drive.standby_request
    |-> !drive.discharge_gate_enable && !drive.sense_pulldown_enable) else $error("bad standby");
  a_charge_drop_delay: assert property (s_charge_drop |-> run[0] >= OC_DETECT_CYCLES
    || run[1] >= ECC_DETECT_CYCLES || $past(sense.delay_shortening)) else $error("early charge off");
  a_discharge_drop_delay: assert property ($fell(drive.discharge_gate_enable)
    |-> run[2] >= OD_DETECT_CYCLES || run[3] >= EDC_DETECT_CYCLES
    || run[4] >= SHORT_DETECT_CYCLES || $past(sense.delay_shortening)) else $error("early off");
  a_standby_release: assert property ($fell(drive.standby_request)
    |-> run[5] >= OD_RELEASE_CYCLES || $past(sense.delay_shortening)) else $error("early wake");
  a_pulldown_release: assert property (s_pulldown_drop
    |-> drive.discharge_gate_enable && run[6] >= EDC_RELEASE_CYCLES) else $error("bad release");
  a_charge_rise_delay: assert property ($rose(drive.charge_gate_enable)
    |-> run[7] >= OC_RELEASE_CYCLES || run[8] >= ECC_RELEASE_CYCLES
    || $past(sense.cell_depleted && sense.charger_present)) else $error("early charge on");
endmodule

bind cell_protection_sequencer cell_protection_props #(
  .OC_DETECT_CYCLES(OC_DETECT_CYCLES), .OC_RELEASE_CYCLES(OC_RELEASE_CYCLES),
  .OD_DETECT_CYCLES(OD_DETECT_CYCLES), .OD_RELEASE_CYCLES(OD_RELEASE_CYCLES),
  .EDC_DETECT_CYCLES(EDC_DETECT_CYCLES), .EDC_RELEASE_CYCLES(EDC_RELEASE_CYCLES),
  .SHORT_DETECT_CYCLES(SHORT_DETECT_CYCLES), .ECC_DETECT_CYCLES(ECC_DETECT_CYCLES),
  .ECC_RELEASE_CYCLES(ECC_RELEASE_CYCLES)
) props_i (.ref_clk(ref_clk), .rst_n(rst_n), .sense(sense), .drive(drive));

// ==== verif/cell_comparators.sv ====
// Comparator model feeding the sequencer from cell and sense node levels
`timescale 1ns/1ns
module cell_comparators
  import cell_protection_pkg::*;
(
  input wire logic signed [15:0] vdd_mv,
  input wire logic signed [15:0] vminus_mv,
  input wire logic charger,
  input wire logic load,
  output cell_sense_s sense
);
  // ****************************************
  // Threshold comparators, levels in mV
  // ****************************************
  always_comb begin
    sense.overcharge_detector = (vdd_mv >= 16'sh10B8); // 4280
    sense.overcharge_release_level = (vdd_mv <= 16'sh1004); // 4100
    sense.overdischarge_detector = (vdd_mv < 16'sh0BB8); // 3000
    sense.overdischarge_release_level = (vdd_mv >= 16'sh0C80); // 3200
    sense.discharge_overcurrent_detector = (vminus_mv >= 16'sh0064); // 100
    sense.short_detector = (vminus_mv >= 16'sh0320); // 800
    sense.charge_overcurrent_detector = (vminus_mv <= -16'sh0064); // -100
    sense.delay_shortening = (vminus_mv <= -16'sh07D0); // -2000
    sense.charger_present = charger;
    sense.load_present = load;
    sense.cell_depleted = (vdd_mv == 16'sh0000);
  end
endmodule

// ==== verif/testbench.sv ====
// Self-checking testbench for the cell protection sequencer
`timescale 1ns/1ns
module testbench import cell_protection_pkg::*; ();
  typedef struct {
    logic signed [15:0] vdd;
    logic signed [15:0] vm;
    logic [1:0] plug;
    logic [7:0] cycles;
    gate_drive_s exp;
  } row_s;
  localparam logic signed [15:0] V4300 = 16'sh10CC, V4200 = 16'sh1068, V4100 = 16'sh1004,
    V3700 = 16'sh0E74, V3200 = 16'sh0C80, V3100 = 16'sh0C1C, V2900 = 16'sh0B54,
    V0 = 16'sh0000, V50 = 16'sh0032, V100 = 16'sh0064, V800 = 16'sh0320;
  // Shortened delay counts for simulation, excess discharge below overdischarge
  localparam int unsigned OC_DET = 32'h28;
  localparam int unsigned OC_REL = 32'h14;
  localparam int unsigned OD_DET = 32'h14;
  localparam int unsigned OD_REL = 32'h0A;
  localparam int unsigned EDC_DET = 32'h0F;
  localparam int unsigned EDC_REL = 32'h0A;
  localparam int unsigned SHORT_DET = 32'h05;
  localparam int unsigned ECC_DET = 32'h0C;
  localparam int unsigned ECC_REL = 32'h0A;
  logic ref_clk = 1'h0;
  logic rst_n = 1'h0;
  logic signed [15:0] vdd_mv = V3700;
  logic signed [15:0] vm_mv = V0;
  logic charger = 1'h1;
  logic load = 1'h0;
  cell_sense_s sense;
  gate_drive_s drive;
  int num_errors = 0;
  int n_compared = 0;
  // ****************************************
  // Rows: levels, charger and load, cycles, expected gates
  // ****************************************
  row_s rows [$] = '{
    '{V4300, V0, 2'h2, 8'h27, 4'hC}, '{V3700, V0, 2'h2, 8'h01, 4'hC},
    '{V4300, V0, 2'h2, 8'h27, 4'hC}, '{V4300, V0, 2'h2, 8'h01, 4'h4},
    '{V4200, V0, 2'h2, 8'h19, 4'h4}, '{V4100, V0, 2'h2, 8'h13, 4'h4},
    '{V4200, V0, 2'h2, 8'h01, 4'h4}, '{V4100, V0, 2'h2, 8'h13, 4'h4},
    '{V4100, V0, 2'h2, 8'h01, 4'hC}, '{V4300, V0, 2'h2, 8'h28, 4'h4},
    '{V4300, V0, 2'h1, 8'h1E, 4'h4}, '{V4200, V0, 2'h1, 8'h13, 4'h4},
    '{V4200, V0, 2'h1, 8'h01, 4'hC}, '{V2900, V0, 2'h1, 8'h13, 4'hC},
    '{V3100, V0, 2'h1, 8'h01, 4'hC}, '{V2900, V0, 2'h1, 8'h14, 4'hA},
    '{V3100, V0, 2'h1, 8'h1E, 4'hA}, '{V3200, V0, 2'h1, 8'h09, 4'hA},
    '{V3200, V0, 2'h1, 8'h01, 4'hC}, '{V2900, V0, 2'h1, 8'h14, 4'hA},
    '{V3100, V0, 2'h2, 8'h09, 4'hA}, '{V3100, V0, 2'h2, 8'h01, 4'hC},
    '{V3700, V100, 2'h1, 8'h0E, 4'hC}, '{V3700, V50, 2'h1, 8'h01, 4'hC},
    '{V3700, V100, 2'h1, 8'h0F, 4'h9}, '{V3700, V0, 2'h1, 8'h09, 4'h9},
    '{V3700, V0, 2'h1, 8'h01, 4'hC}, '{V3700, V800, 2'h1, 8'h04, 4'hC},
    '{V3700, V800, 2'h1, 8'h01, 4'h9}, '{V3700, V0, 2'h1, 8'h0A, 4'hC},
    '{V3700, -V100, 2'h2, 8'h0B, 4'hC}, '{V3700, V0, 2'h2, 8'h01, 4'hC},
    '{V3700, -V100, 2'h2, 8'h0C, 4'h4}, '{V3700, V0, 2'h2, 8'h1E, 4'h4},
    '{V3700, V0, 2'h1, 8'h09, 4'h4}, '{V3700, V0, 2'h1, 8'h01, 4'hC},
    '{V2900, V100, 2'h1, 8'h0F, 4'h9}, '{V3700, V0, 2'h1, 8'h0A, 4'hC},
    '{V3700, -V100, 2'h2, 8'h0C, 4'h4}, '{V0, V0, 2'h2, 8'h01, 4'hC},
    '{V0, V0, 2'h2, 8'h13, 4'hA}};
  always #5 ref_clk = ~ref_clk;
  cell_comparators cell_comparators_i (.vdd_mv(vdd_mv), .vminus_mv(vm_mv), .charger(charger),
    .load(load), .sense(sense));
  cell_protection_sequencer #(.OC_DETECT_CYCLES(OC_DET), .OC_RELEASE_CYCLES(OC_REL),
    .OD_DETECT_CYCLES(OD_DET), .OD_RELEASE_CYCLES(OD_REL), .EDC_DETECT_CYCLES(EDC_DET),
    .EDC_RELEASE_CYCLES(EDC_REL), .SHORT_DETECT_CYCLES(SHORT_DET), .ECC_DETECT_CYCLES(ECC_DET),
    .ECC_RELEASE_CYCLES(ECC_REL)) cell_protection_sequencer_i (.ref_clk(ref_clk),
    .rst_n(rst_n), .sense(sense), .drive(drive));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic check_drive(input gate_drive_s exp);
    n_compared++;
    if (drive !== exp) begin
      num_errors++;
      $display("unexpected drive at %0t: got %h expected %h", $time, drive, exp);
    end
  endtask
  task automatic apply(input row_s r);
    vdd_mv = r.vdd;
    vm_mv = r.vm;
    {charger, load} = r.plug;
    repeat (r.cycles) @(posedge ref_clk);
    @(negedge ref_clk);
    check_drive(r.exp);
  endtask
  task give_verdict;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge ref_clk);
    check_drive(4'hC);
    rst_n = 1'h1;
    foreach (rows[i]) apply(rows[i]);
    rst_n = 1'h0;
    apply('{V4300, -16'sh07D0, 2'h2, 8'h02, 4'hC});
    rst_n = 1'h1;
    apply('{V4300, -16'sh07D0, 2'h2, 8'h02, 4'h4});
    give_verdict();
  end
endmodule
